// [src/tmc_thermal_ctrl.sv]
// Thermal monitor control: trip handling, throttle modes, status and interrupt
//
// Behaviour
// R01: Catastrophic trip halts execution until reset; always enabled.
// R02: Misc enable bit 3 enables duty-cycle throttling.
// R03: Reset clears misc enable bit 3.
// R04: Duty-cycle mode gates core clock internally; external stop pin unused.
// R05: Frequency/voltage mode uses the same trip sensor.
// R06: Early parts: frequency/voltage mode needs mode-select bit 16 and bit 3.
// R07: Early parts: bit 3 set, mode-select clear selects duty-cycle mode.
// R08: Later parts: misc enable bit 13 enables frequency/voltage mode.
// R09: Engaged frequency/voltage mode drives target point from control bits 15:0.
// R10: Firmware enables one mode; software never disables it.
// R11: Software leaves the target operating-point field alone once programmed.
// R12: Duty-cycle engaged: performance target takes effect immediately.
// R13: Frequency/voltage engaged: performance target held until disengage.
// R14: Status bit 0 read-only, shows engaged throttle state.
// R15: Status bit 1 sticky log set on trip, reset to zero.
// R16: Writing zero clears the log; writing one leaves it.
// R17: Throttle stays engaged at least about 1 ms after trip.
// R18: Then stays engaged until the sensor reports below trip.
// R19: Interrupts held during clock stop, delivered afterwards.
// R20: High enable bit 0 raises interrupt on rising trip.
// R21: Low enable bit 1 raises interrupt on falling trip.
// R22: Reset clears interrupt enables and masks the vector entry.
// R23: Throttling never alters time stamp counter rate.
`timescale 1ns/1ns
module tmc_thermal_ctrl
  import tmc_pkg::*;
#(
  parameter int  MIN_ENGAGE = MIN_ENGAGE_CYC,
  parameter bit  EARLY_PART = 1'b0
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Temperature trip sensors
  input  wire logic              catastrophic_trip,
  input  wire logic              thermal_trip,
  // Core controls
  output logic                   core_halt,
  output logic                   core_clk_gate,
  output logic      [OP_W-1:0]   target_op_point,
  output logic                   fv_transition,
  output logic      [63:0]       time_stamp,
  // Local interrupt controller
  output logic                   thermal_irq,
  output logic      [VEC_W-1:0]  thermal_vector
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] cat_sync;
  logic [2:0] trip_sync;
  logic       trip_level;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cat_sync  <= 3'h0;
      trip_sync <= 3'h0;
    end else begin
      cat_sync  <= {cat_sync[1:0], catastrophic_trip};
      trip_sync <= {trip_sync[1:0], thermal_trip};
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_level <= 1'b0;
    end else if (trip_sync[1] == trip_sync[2]) begin
      trip_level <= trip_sync[2];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]      misc_enable_register;
  logic [31:0]      thermal_interrupt_enables;
  logic [16:0]      second_throttle_control;
  logic [OP_W-1:0]  performance_target_register;
  logic [VEC_W:0]   local_vector_entries;
  logic             status_log;
  logic             engaged;
  logic             pending_irq;

  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == ADDR_MISC_ENABLE) || (paddr == ADDR_STATUS)
                || (paddr == ADDR_INT_ENABLE) || (paddr == ADDR_THROTTLE_CTL)
                || (paddr == ADDR_PERF_TARGET) || (paddr == ADDR_VECTOR_ENTRY)
                || (paddr == ADDR_OPERATING_PT) || (paddr == ADDR_CORE_STATE);
  assign pslverr = psel && penable && !addr_ok;

  // ---------------------------------------------------------------
  // Write strobes, one per writable register
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input logic        wr,
                                  input logic [11:0] a,
                                  input logic [11:0] target);
    return wr && (a == target);
  endfunction : wr_hit

  logic wr_misc;
  logic wr_status;
  logic wr_int_en;
  logic wr_ctl;
  logic wr_vec;
  logic wr_perf;
  assign wr_misc   = wr_hit(apb_wr, paddr, ADDR_MISC_ENABLE);
  assign wr_status = wr_hit(apb_wr, paddr, ADDR_STATUS);
  assign wr_int_en = wr_hit(apb_wr, paddr, ADDR_INT_ENABLE);
  assign wr_ctl    = wr_hit(apb_wr, paddr, ADDR_THROTTLE_CTL);
  assign wr_vec    = wr_hit(apb_wr, paddr, ADDR_VECTOR_ENTRY);
  assign wr_perf   = wr_hit(apb_wr, paddr, ADDR_PERF_TARGET);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_enable_register <= MISC_RESET; // R03
    end else if (wr_misc) begin
      misc_enable_register <= pwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_interrupt_enables <= INT_EN_RESET; // R22
    end else if (wr_int_en) begin
      thermal_interrupt_enables <= pwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_throttle_control <= CTL_RESET;
    end else if (wr_ctl) begin
      second_throttle_control <= pwdata[16:0];
    end
  end

  // Vector entry: mask bit plus vector number; reset masked
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      local_vector_entries <= {1'b1, VEC_RESET}; // R22
    end else if (wr_vec) begin
      local_vector_entries <= {pwdata[VEC_MASK_BIT], pwdata[VEC_W-1:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      performance_target_register <= OP_RESET;
    end else if (wr_perf) begin
      performance_target_register <= pwdata[OP_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------
  tmc_mode_s mode;
  always_comb begin
    if (EARLY_PART) begin
      mode.fv_mode   = misc_enable_register[MISC_DUTY_EN_BIT]
                    && second_throttle_control[CTL_MODE_SEL_BIT]; // R06
      mode.duty_mode = misc_enable_register[MISC_DUTY_EN_BIT]
                    && !second_throttle_control[CTL_MODE_SEL_BIT]; // R07
    end else begin
      mode.fv_mode   = misc_enable_register[MISC_FV_EN_BIT]; // R08
      mode.duty_mode = misc_enable_register[MISC_DUTY_EN_BIT]
                    && !misc_enable_register[MISC_FV_EN_BIT]; // R02
    end
  end

  // ---------------------------------------------------------------
  // Catastrophic halt
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_halt <= 1'b0;
    end else if (cat_sync[2] && cat_sync[1]) begin
      core_halt <= 1'b1; // R01
    end
  end

  // ---------------------------------------------------------------
  // Throttle engage state machine
  // ---------------------------------------------------------------
  tmc_throttle_e state;
  logic [31:0]   hold_cnt;
  logic          any_mode;
  assign any_mode = mode.duty_mode || mode.fv_mode;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= TMC_IDLE;
      hold_cnt <= 32'h0;
    end else begin
      case (state)
        TMC_IDLE: begin
          if (trip_level && any_mode) begin // R05
            state    <= TMC_MIN_HOLD;
            hold_cnt <= 32'(MIN_ENGAGE - 1);
          end
        end
        TMC_MIN_HOLD: begin
          if (hold_cnt == 32'h0) begin
            state <= TMC_WAIT_COOL; // R17
          end else begin
            hold_cnt <= hold_cnt - 32'h1;
          end
        end
        TMC_WAIT_COOL: begin
          if (!trip_level) begin
            state <= TMC_IDLE; // R18
          end
        end
        default: state <= TMC_IDLE;
      endcase
    end
  end
  assign engaged = (state != TMC_IDLE);

  // ---------------------------------------------------------------
  // Duty-cycle gating of the core clock (internal stop-clock)
  // ---------------------------------------------------------------
  // Free-running phase counter; one wrap is one stop-clock period
  localparam int DUTY_W = $clog2(DUTY_PERIOD);
  logic [DUTY_W-1:0] duty_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      duty_cnt <= '0;
    end else begin
      duty_cnt <= duty_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_clk_gate <= 1'b0;
    end else begin
      core_clk_gate <= (engaged && mode.duty_mode && 32'(duty_cnt) < DUTY_STOP)
                    || core_halt; // R04
    end
  end

  // ---------------------------------------------------------------
  // Operating point: thermal target vs. performance target
  // ---------------------------------------------------------------
  logic fv_engaged;
  assign fv_engaged = engaged && mode.fv_mode;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_op_point <= OP_RESET;
      fv_transition   <= 1'b0;
    end else begin
      fv_transition <= fv_engaged;
      if (fv_engaged) begin
        target_op_point <= second_throttle_control[OP_W-1:0]; // R09 R13
      end else begin
        target_op_point <= performance_target_register; // R12
      end
    end
  end

  // ---------------------------------------------------------------
  // Status log
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_log <= 1'b0;
    end else if (trip_level) begin
      status_log <= 1'b1; // R15
    end else if (wr_status && !pwdata[STAT_LOG_BIT]) begin
      status_log <= 1'b0; // R16
    end
  end

  // ---------------------------------------------------------------
  // Thermal interrupt, held off while the clock is stopped
  // ---------------------------------------------------------------
  logic trip_prev;
  logic rise_evt;
  logic fall_evt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_prev <= 1'b0;
    end else begin
      trip_prev <= trip_level;
    end
  end
  assign rise_evt = trip_level && !trip_prev
                 && thermal_interrupt_enables[INT_HIGH_EN_BIT]; // R20
  assign fall_evt = !trip_level && trip_prev
                 && thermal_interrupt_enables[INT_LOW_EN_BIT]; // R21

  // A new event wins over delivery in the same cycle, so none is lost
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_irq <= 1'b0;
    end else if (rise_evt || fall_evt) begin
      pending_irq <= 1'b1;
    end else if (!core_clk_gate && !local_vector_entries[VEC_W]) begin
      pending_irq <= 1'b0; // R19
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_irq <= 1'b0;
    end else begin
      thermal_irq <= pending_irq && !core_clk_gate && !local_vector_entries[VEC_W]; // R19
    end
  end
  assign thermal_vector = local_vector_entries[VEC_W-1:0];

  // ---------------------------------------------------------------
  // Time stamp counter runs on the undivided clock
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      time_stamp <= 64'h0;
    end else begin
      time_stamp <= time_stamp + 64'h1; // R23
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata = 32'h0;
    if (!apb_rd) begin
      prdata = 32'h0;
    end else if (paddr == ADDR_MISC_ENABLE) begin
      prdata = misc_enable_register;
    end else if (paddr == ADDR_STATUS) begin
      prdata[STAT_HOT_BIT] = engaged; // R14
      prdata[STAT_LOG_BIT] = status_log;
    end else if (paddr == ADDR_INT_ENABLE) begin
      prdata = thermal_interrupt_enables;
    end else if (paddr == ADDR_THROTTLE_CTL) begin
      prdata[16:0] = second_throttle_control;
    end else if (paddr == ADDR_PERF_TARGET) begin
      prdata[OP_W-1:0] = performance_target_register;
    end else if (paddr == ADDR_VECTOR_ENTRY) begin
      prdata[VEC_MASK_BIT] = local_vector_entries[VEC_W];
      prdata[VEC_W-1:0]    = local_vector_entries[VEC_W-1:0];
    end else if (paddr == ADDR_OPERATING_PT) begin
      prdata[OP_W-1:0] = target_op_point;
    end else if (paddr == ADDR_CORE_STATE) begin
      prdata[0] = core_halt;
      prdata[1] = core_clk_gate;
      prdata[2] = pending_irq;
    end
  end

endmodule : tmc_thermal_ctrl

// [src/tmc_pkg.sv]
// Package: register map, field positions and timing for the thermal monitor control
package tmc_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_MISC_ENABLE   = 12'h000;
  localparam logic [11:0] ADDR_STATUS        = 12'h004;
  localparam logic [11:0] ADDR_INT_ENABLE    = 12'h008;
  localparam logic [11:0] ADDR_THROTTLE_CTL  = 12'h00c;
  localparam logic [11:0] ADDR_PERF_TARGET   = 12'h010;
  localparam logic [11:0] ADDR_VECTOR_ENTRY  = 12'h014;
  localparam logic [11:0] ADDR_OPERATING_PT  = 12'h018;
  localparam logic [11:0] ADDR_CORE_STATE    = 12'h01c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MISC_DUTY_EN_BIT   = 3;
  localparam int MISC_FV_EN_BIT     = 13;
  localparam int CTL_MODE_SEL_BIT   = 16;
  localparam int STAT_HOT_BIT       = 0;
  localparam int STAT_LOG_BIT       = 1;
  localparam int INT_HIGH_EN_BIT    = 0;
  localparam int INT_LOW_EN_BIT     = 1;
  localparam int VEC_MASK_BIT       = 16;
  localparam int OP_W               = 16;
  localparam int VEC_W              = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] MISC_RESET       = 32'h0000_0000;
  localparam logic [31:0] INT_EN_RESET     = 32'h0000_0000;
  localparam logic [16:0] CTL_RESET        = 17'h0_0000;
  localparam logic [15:0] OP_RESET         = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int MIN_ENGAGE_US  = 1000;
  localparam int MIN_ENGAGE_CYC = MIN_ENGAGE_US * CLK_MHZ;
  localparam int DUTY_PERIOD    = 8;
  localparam int DUTY_STOP      = 4;

  typedef enum logic [1:0] {
    TMC_IDLE,
    TMC_MIN_HOLD,
    TMC_WAIT_COOL
  } tmc_throttle_e;

  typedef struct packed {
    logic        duty_mode;
    logic        fv_mode;
  } tmc_mode_s;

endpackage : tmc_pkg

// [tb/tmc_thermal_ctrl_sva.sv]
// Checker: port-level properties of the thermal monitor control
`timescale 1ns/1ns
module tmc_thermal_ctrl_sva
  import tmc_pkg::*;
#(
  parameter int MIN_ENGAGE = MIN_ENGAGE_CYC
) (
  // Clock and reset
  input wire logic            sys_clk,
  input wire logic            rst_b,
  // Sensor
  input wire logic            thermal_trip,
  // Core side
  input wire logic            core_halt,
  input wire logic            core_clk_gate,
  input wire logic [OP_W-1:0] target_op_point,
  input wire logic            fv_transition,
  input wire logic [63:0]     time_stamp,
  // Interrupt request
  input wire logic            thermal_irq
);
  // ---------------------------------------------------------------
  // Length of the current frequency/voltage engagement
  // ---------------------------------------------------------------
  int unsigned fv_len;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      fv_len <= 0;
    else if (fv_transition)
      fv_len <= fv_len + 1;
    else
      fv_len <= 0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_halt_sticky: assert property (core_halt |=> core_halt)
    else $error("halt released without reset");
  chk_halt_gates: assert property (core_halt && $past(core_halt) |-> core_clk_gate)
    else $error("clock running while halted");
  chk_tsc_step: assert property ($past(rst_b) |-> time_stamp == $past(time_stamp) + 64'h1)
    else $error("time stamp did not advance by one");
  chk_fv_min_hold: assert property ($fell(fv_transition) |-> fv_len >= MIN_ENGAGE)
    else $error("throttle released before minimum period");
  chk_fv_no_gate: assert property (fv_transition && !core_halt |-> !core_clk_gate)
    else $error("clock gated in frequency mode");
  chk_gate_bounded: assert property ($rose(core_clk_gate) && !core_halt
    |-> ##[1:5] (!core_clk_gate || core_halt))
    else $error("duty gating too long");
  chk_fv_target_hold: assert property (fv_transition && $past(fv_transition)
    |-> $stable(target_op_point))
    else $error("operating point moved while frequency throttle engaged");
  chk_fv_release_cool: assert property ($fell(fv_transition)
    |-> !thermal_trip && !$past(thermal_trip, 2))
    else $error("throttle released while sensor hot");
  chk_irq_held: assert property (thermal_irq |-> !$past(core_clk_gate))
    else $error("interrupt delivered while clock stopped");
endmodule : tmc_thermal_ctrl_sva

bind tmc_thermal_ctrl tmc_thermal_ctrl_sva #(.MIN_ENGAGE(MIN_ENGAGE)) i_tmc_thermal_ctrl_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .thermal_trip(thermal_trip), .core_halt(core_halt),
  .core_clk_gate(core_clk_gate), .target_op_point(target_op_point),
  .fv_transition(fv_transition), .time_stamp(time_stamp), .thermal_irq(thermal_irq));

// [tb/tmc_sensor_model.sv]
// Partner model: trip sensors and the interrupt controller input
`timescale 1ns/1ns
module tmc_sensor_model (
  // Clock
  input  wire logic sys_clk,
  // Requested die conditions
  input  wire logic hot,
  input  wire logic crit,
  // Sensor pins
  output logic      thermal_trip,
  output logic      catastrophic_trip,
  // Interrupt controller
  input  wire logic thermal_irq,
  output int        irq_count
);
  bit irq_q;
  // Trip levels follow the die condition one cycle late
  always @(posedge sys_clk) begin
    thermal_trip <= hot;
    catastrophic_trip <= crit;
  end
  // Each rising edge of the request is one delivered interrupt
  always @(posedge sys_clk) begin
    irq_q <= (thermal_irq === 1'b1);
    if (thermal_irq === 1'b1 && !irq_q)
      irq_count <= irq_count + 1;
  end
endmodule : tmc_sensor_model

// [tb/tb_tmc_thermal_ctrl.sv]
// Testbench: thermal monitor control scenarios over APB and trip pins
`timescale 1ns/1ns
module tb_tmc_thermal_ctrl;
  import tmc_pkg::*;
  localparam int MINE = 20;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        hot     = 1'b0;
  logic        crit    = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e, thermal_trip, catastrophic_trip, core_halt;
  logic        core_clk_gate, fv_transition, thermal_irq;
  logic        early_gate, early_fv;
  logic [15:0] target_op_point;
  logic [63:0] time_stamp;
  logic [7:0]  thermal_vector;
  int          irq_count;
  int          miscompares = 0;
  int          num_checks  = 0;

  always #2 sys_clk = ~sys_clk;

  tmc_thermal_ctrl #(.MIN_ENGAGE(MINE), .EARLY_PART(1'b0)) i_tmc_thermal_ctrl (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .catastrophic_trip(catastrophic_trip), .thermal_trip(thermal_trip),
    .core_halt(core_halt), .core_clk_gate(core_clk_gate), .target_op_point(target_op_point),
    .fv_transition(fv_transition), .time_stamp(time_stamp), .thermal_irq(thermal_irq),
    .thermal_vector(thermal_vector));
  tmc_thermal_ctrl #(.MIN_ENGAGE(MINE), .EARLY_PART(1'b1)) i_tmc_thermal_ctrl_early (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .catastrophic_trip(catastrophic_trip), .thermal_trip(thermal_trip),
    .core_halt(), .core_clk_gate(early_gate), .target_op_point(),
    .fv_transition(early_fv), .time_stamp(), .thermal_irq(), .thermal_vector());
  tmc_sensor_model i_tmc_sensor_model (.sys_clk(sys_clk), .hot(hot), .crit(crit),
    .thermal_trip(thermal_trip), .catastrophic_trip(catastrophic_trip),
    .thermal_irq(thermal_irq), .irq_count(irq_count));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic heat(input logic h, input int n);
    hot <= h;
    repeat (n) @(posedge sys_clk);
  endtask : heat

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    check(core_halt, 1'b0, "halt after reset");
    apb(1'b0, ADDR_MISC_ENABLE, 32'h0);
    check(q[MISC_DUTY_EN_BIT], 1'b0, "duty enable after reset");
    apb(1'b0, ADDR_INT_ENABLE, 32'h0);
    check(q[1:0], 2'b00, "interrupt enables after reset");
    apb(1'b0, ADDR_VECTOR_ENTRY, 32'h0);
    check(q[VEC_MASK_BIT], 1'b1, "vector masked after reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[1:0], 2'b00, "status after reset");
    $display("test reset values done");
  endtask : t_reset_vals

  task automatic t_duty();
    int g;
    int h;
    int b;
    g = 0;
    h = 0;
    apb(1'b1, ADDR_MISC_ENABLE, 32'h0000_0008);
    heat(1'b1, 6);
    heat(1'b0, 6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[1:0], 2'b11, "short trip still engaged and logged");
    heat(1'b0, 40);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[1:0], 2'b10, "cooled with log kept");
    apb(1'b1, ADDR_STATUS, 32'h0000_0003);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[1:0], 2'b10, "write of ones leaves flags");
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[1], 1'b0, "log cleared by zero");
    apb(1'b1, ADDR_VECTOR_ENTRY, 32'h0000_0042);
    apb(1'b1, ADDR_INT_ENABLE, 32'h0000_0002);
    b = irq_count;
    heat(1'b1, 10);
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      g += (core_clk_gate === 1'b1);
      h += (early_gate === 1'b1);
    end
    check(g, DUTY_STOP * 2, "gated cycles in two periods");
    check(h, DUTY_STOP * 2, "early part duty gating");
    check(fv_transition, 1'b0, "no frequency throttle in duty mode");
    check(early_fv, 1'b0, "early part stays in duty mode");
    apb(1'b1, ADDR_PERF_TARGET, 32'h0000_0055);
    repeat (3) @(posedge sys_clk);
    check(target_op_point, 16'h0055, "perf target during duty throttle");
    heat(1'b0, 40);
    check(irq_count - b, 1, "fall interrupt held past gating");
    $display("test duty throttle done");
  endtask : t_duty

  task automatic t_fv();
    apb(1'b1, ADDR_THROTTLE_CTL, 32'h0001_00a5);
    apb(1'b1, ADDR_MISC_ENABLE, 32'h0000_2008);
    heat(1'b1, 10);
    check(fv_transition, 1'b1, "frequency throttle engaged");
    check(core_clk_gate, 1'b0, "no gating in frequency mode");
    check(target_op_point, 16'h00a5, "thermal target applied");
    check(early_fv, 1'b1, "early part frequency throttle with select");
    apb(1'b0, ADDR_OPERATING_PT, 32'h0);
    check(q[15:0], 16'h00a5, "operating point readback");
    apb(1'b1, ADDR_PERF_TARGET, 32'h0000_0033);
    repeat (3) @(posedge sys_clk);
    check(target_op_point, 16'h00a5, "perf target held while engaged");
    heat(1'b0, 40);
    check(fv_transition, 1'b0, "frequency throttle released");
    check(target_op_point, 16'h0033, "perf target after release");
    $display("test frequency throttle done");
  endtask : t_fv

  task automatic t_irq();
    int b;
    apb(1'b1, ADDR_VECTOR_ENTRY, 32'h0000_0042);
    apb(1'b1, ADDR_INT_ENABLE, 32'h0000_0001);
    b = irq_count;
    heat(1'b1, 30);
    check(irq_count - b, 1, "interrupt on rising trip");
    check(thermal_vector, 8'h42, "vector number");
    heat(1'b0, 40);
    check(irq_count - b, 1, "no interrupt on fall while disabled");
    apb(1'b1, ADDR_INT_ENABLE, 32'h0000_0002);
    heat(1'b1, 30);
    heat(1'b0, 40);
    check(irq_count - b, 2, "interrupt on falling trip only");
    apb(1'b1, ADDR_VECTOR_ENTRY, 32'h0001_0042);
    apb(1'b1, ADDR_INT_ENABLE, 32'h0000_0003);
    heat(1'b1, 30);
    check(irq_count - b, 2, "masked entry blocks interrupt");
    heat(1'b0, 40);
    $display("test interrupts done");
  endtask : t_irq

  task automatic t_halt();
    apb(1'b0, 12'h020, 32'h0);
    check(e, 1'b1, "unmapped read refused");
    crit <= 1'b1;
    repeat (8) @(posedge sys_clk);
    crit <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check(core_halt, 1'b1, "halt held after trip clears");
    check(core_clk_gate, 1'b1, "clock stopped while halted");
    apb(1'b0, ADDR_CORE_STATE, 32'h0);
    check(q[1:0], 2'b11, "halt and gate readback");
    do_reset();
    t_reset_vals();
    $display("test halt done");
  endtask : t_halt

  initial begin
    do_reset();
    t_reset_vals();
    t_duty();
    t_fv();
    t_irq();
    t_halt();
    conclude();
  end

  initial begin
    #40000;
    miscompares++;
    conclude();
  end
endmodule : tb_tmc_thermal_ctrl
